// [hw/alert_pkg.sv]
// Purpose: shared constants for the fault/warning alert block
// Assumes: 32-bit AHB-Lite register bus, 12-bit converter codes
// Notes:   status bit positions double as alert-enable bit positions
package alert_pkg;

  // register byte offsets
  localparam logic [7:0] CTRL_OFS        = 8'h00;
  localparam logic [7:0] ALERT_EN_OFS    = 8'h04;
  localparam logic [7:0] STATUS_OFS      = 8'h08;
  localparam logic [7:0] VOUT_UV_OFS     = 8'h0C;
  localparam logic [7:0] VOUT_OV_OFS     = 8'h10;
  localparam logic [7:0] VIN_UV_OFS      = 8'h14;
  localparam logic [7:0] VIN_OV_OFS      = 8'h18;
  localparam logic [7:0] IOUT_OC_OFS     = 8'h1C;
  localparam logic [7:0] IOUT_WARN2_OFS  = 8'h20;
  localparam logic [7:0] PIN_OP_OFS      = 8'h24;
  localparam logic [7:0] READ_VIN_OFS    = 8'h28;
  localparam logic [7:0] READ_VOUT_OFS   = 8'h2C;
  localparam logic [7:0] READ_IOUT_OFS   = 8'h30;
  localparam logic [7:0] PEAK_VIN_OFS    = 8'h34;
  localparam logic [7:0] PEAK_VOUT_OFS   = 8'h38;
  localparam logic [7:0] CUR_PEAK_OFS    = 8'h3C;
  localparam logic [7:0] LINE_STATE_OFS  = 8'h40;

  // control register fields, plus the warn2 under-limit bit
  localparam int CTRL_CLEAR_BIT  = 0;
  localparam int CTRL_ON_BIT     = 1;
  localparam int CTRL_INVERT_BIT = 2;
  localparam int CTRL_ADDR_LSB   = 8;
  localparam int WARN2_UNDER_BIT = 16;

  // status bit positions
  localparam int ST_UV_FAULT  = 0;
  localparam int ST_OV_FAULT  = 1;
  localparam int ST_OC_FAULT  = 2;
  localparam int ST_CML       = 3;
  localparam int ST_TIMER     = 4;
  localparam int ST_IOUT_OC   = 5;
  localparam int ST_IOUT_W2   = 6;
  localparam int ST_VIN_UV    = 7;
  localparam int ST_VIN_OV    = 8;
  localparam int ST_VOUT_UV   = 9;
  localparam int ST_VOUT_OV   = 10;
  localparam int ST_PIN_OP    = 11;
  localparam int ST_FET_BAD   = 15;

  // reset values
  localparam logic [15:0] ALERT_EN_RST  = 16'h8000;
  localparam logic [11:0] OV_LIMIT_RST  = 12'hFFF;
  localparam logic [11:0] UV_LIMIT_RST  = 12'h000;
  localparam logic [15:0] PIN_LIMIT_RST = 16'h7FFF;
  localparam logic [6:0]  DEV_ADDR_RST  = 7'h40;

  // code meaning (software conversion only)
  localparam int CURRENT_ZERO_CODE   = 2048;
  localparam int CURRENT_STEP_NV     = 12400;
  localparam int VOLT_STEP_6V_UV     = 1488;
  localparam int VOLT_STEP_20V_UV    = 5208;

  // smbus alert response address, read direction
  localparam logic [6:0] ARA_ADDR = 7'h0C;
  localparam logic [3:0] BITS_PER_BYTE = 4'd8;

endpackage

// [hw/ara_if.sv]
// Purpose: carries the synchronised bus lines and alert handshake
// Assumes: all signals on hclk
// Notes:   scl/sda arrive already through two flip-flops
`timescale 1ns/1ps
interface ara_if;
  logic       scl;
  logic       sda;
  logic       alert_active;
  logic [6:0] dev_addr;
  logic       sda_oe;
  logic       won;

  modport ctrl (output scl, output sda, output alert_active, output dev_addr,
                input sda_oe, input won);
  modport resp (input scl, input sda, input alert_active, input dev_addr,
                output sda_oe, output won);
endinterface

// [hw/ara_responder.sv]
// Purpose: answers alert response address reads with bitwise arbitration
// Assumes: scl and sda already synchronised to hclk
// Notes:   sda changes only after scl falls; one clean win per read
`timescale 1ns/1ps
module ara_responder
  import alert_pkg::*;
(
  // clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // link to top
  ara_if.resp       bus
);

  typedef enum logic [2:0] {IDLE, ADDR, ACK_WAIT, ACK, TX, NACK} ara_state_t;

  ara_state_t state;
  logic       scl_d;
  logic       sda_d;
  logic [3:0] bit_cnt;
  logic [7:0] shift;

  wire scl_rise = bus.scl & ~scl_d;
  wire scl_fall = ~bus.scl & scl_d;
  wire start_c  = scl_d & bus.scl & sda_d & ~bus.sda;
  wire stop_c   = scl_d & bus.scl & ~sda_d & bus.sda;
  wire [7:0] addr_byte = {shift[6:0], bus.sda};
  wire ara_hit  = (addr_byte == {ARA_ADDR, 1'b1}) & bus.alert_active;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state      <= IDLE;
      scl_d      <= 1'b1;
      sda_d      <= 1'b1;
      bit_cnt    <= 4'd0;
      shift      <= 8'h00;
      bus.sda_oe <= 1'b0;
      bus.won    <= 1'b0;
    end else begin
      scl_d   <= bus.scl;
      sda_d   <= bus.sda;
      bus.won <= 1'b0;
      if (start_c) begin
        state      <= ADDR;
        bit_cnt    <= 4'd0;
        bus.sda_oe <= 1'b0;
      end else if (stop_c) begin
        state      <= IDLE;
        bus.sda_oe <= 1'b0;
      end else begin
        case (state)
          ADDR: if (scl_rise) begin
            shift   <= addr_byte;
            bit_cnt <= bit_cnt + 4'd1;
            if (bit_cnt == BITS_PER_BYTE - 4'd1) begin
              state <= ara_hit ? ACK_WAIT : IDLE;
            end
          end
          ACK_WAIT: if (scl_fall) begin
            bus.sda_oe <= 1'b1;
            state      <= ACK;
          end
          ACK: if (scl_fall) begin
            // address in the upper seven bits, low bit sent as one
            shift      <= {bus.dev_addr, 1'b1};
            bus.sda_oe <= ~bus.dev_addr[6];
            bit_cnt    <= 4'd0;
            state      <= TX;
          end
          TX: begin
            if (scl_rise && !bus.sda_oe && !bus.sda) begin
              // a lower address pulled the line: back off
              bus.sda_oe <= 1'b0;
              state      <= IDLE;
            end else if (scl_fall) begin
              bit_cnt <= bit_cnt + 4'd1;
              shift   <= {shift[6:0], 1'b1};
              if (bit_cnt == BITS_PER_BYTE - 4'd1) begin
                bus.sda_oe <= 1'b0;
                state      <= NACK;
              end else begin
                bus.sda_oe <= ~shift[6];
              end
            end
          end
          NACK: if (scl_rise) begin
            bus.won <= 1'b1;
            state   <= IDLE;
          end
          default: state <= IDLE;
        endcase
      end
    end
  end

endmodule

// [hw/fault_warning_alert_logic.sv]
// Purpose: latches faults and warnings, drives the alert pin, AHB-Lite registers
// Assumes: hclk 25 MHz; analog pins asynchronous; converter samples on hclk
// Notes:   zero-wait-state slave; write data lands one cycle after its address
//
// How it works
// - readbacks and peaks are raw 12-bit codes
// - current code 2048 is zero, 12.4 uV steps
// - voltage equals step times code plus half
// - three analog faults, each turns output off
// - faults always monitored, set status bits
// - status bit one means active, latched
// - clear command or off-on cycle clears bits
// - warnings never change the output state
// - regulation activity sets timer warning
// - alert released after reset, fet-bad only enabled
// - enabled source asserts alert, optional inversion
// - output undervoltage sample below limit alerts
// - clear releases alert, persistent fault stays quiet
// - next violating sample after clear alerts again
// - answer address in seven upper bits
// - lowest address wins arbitration, winner releases
// - violation only when strictly beyond limit
// - winner releases alert during the nack bit
// - alert only on zero-to-one enabled bit
`timescale 1ns/1ps
module fault_warning_alert_logic
  import alert_pkg::*;
(
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // analog event pins, asynchronous
  input  wire logic        uv_pin_event,
  input  wire logic        ov_pin_event,
  input  wire logic        oc_timer_expired,
  input  wire logic        regulation_timer_active_flag,
  input  wire logic        fet_health_bad,
  // converter samples and bus error, on hclk
  input  wire logic        sample_valid,
  input  wire logic [11:0] sample_vin,
  input  wire logic [11:0] sample_vout,
  input  wire logic [11:0] sample_iout,
  input  wire logic [15:0] sample_pin,
  input  wire logic        cml_error,
  // hot swap gate enable
  output logic             hot_swap_on,
  // open-drain alert pin
  input  wire logic        alert_out_pin_i,
  output logic             alert_out_pin_o,
  output logic             alert_out_pin_oe,
  // smbus pins
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe
);

  ara_if ara ();

  // two-flop synchronisers for all pin inputs
  logic [7:0] sync1;
  logic [7:0] sync2;
  wire  [7:0] pins_raw = {alert_out_pin_i, sda_i, scl_i, fet_health_bad,
                          regulation_timer_active_flag, oc_timer_expired, ov_pin_event, uv_pin_event};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1 <= 8'hE0;
      sync2 <= 8'hE0;
    end else begin
      sync1 <= pins_raw;
      sync2 <= sync1;
    end
  end

  // registers
  logic        output_on;
  logic        invert;
  logic [6:0]  dev_addr;
  logic [15:0] alert_en;
  logic [15:0] status;
  logic [11:0] vout_uv_lim;
  logic [11:0] vout_ov_lim;
  logic [11:0] vin_uv_lim;
  logic [11:0] vin_ov_lim;
  logic [11:0] iout_oc_lim;
  logic [11:0] iout_w2_lim;
  logic        warn2_under;
  logic [15:0] pin_op_lim;
  logic [11:0] read_vin;
  logic [11:0] read_vout;
  logic [11:0] read_iout;
  logic [11:0] peak_vin;
  logic [11:0] peak_vout;
  logic [11:0] current_peak_hold;
  logic        alert_signal;
  logic        on_d;

  // bus address phase capture
  logic        wr_pend;
  logic [7:0]  wr_addr;

  wire        addr_phase = hsel & htrans[1] & hready;
  wire [7:0]  rd_ofs     = haddr[7:0];
  wire        wr_now     = wr_pend;
  wire        w_ctrl     = wr_now & (wr_addr == CTRL_OFS);
  wire        clear_cmd  = w_ctrl & hwdata[CTRL_CLEAR_BIT];
  wire        off_on     = output_on & ~on_d;

  // fault and warning causes
  wire uv_f  = sync2[0];
  wire ov_f  = sync2[1];
  wire oc_f  = sync2[2];
  wire regl  = sync2[3];
  wire fbad  = sync2[4];
  wire w2_hit = warn2_under ? (sample_iout < iout_w2_lim) : (sample_iout > iout_w2_lim);

  logic [15:0] cause;
  always_comb begin
    cause              = 16'h0000;
    cause[ST_UV_FAULT] = uv_f;
    cause[ST_OV_FAULT] = ov_f;
    cause[ST_OC_FAULT] = oc_f;
    cause[ST_CML]      = cml_error;
    cause[ST_TIMER]    = regl;
    // converter warnings are evaluated per sample, strict comparisons
    cause[ST_IOUT_OC]  = sample_valid & (sample_iout > iout_oc_lim);
    cause[ST_IOUT_W2]  = sample_valid & w2_hit;
    cause[ST_VIN_UV]   = sample_valid & (sample_vin < vin_uv_lim);
    cause[ST_VIN_OV]   = sample_valid & (sample_vin > vin_ov_lim);
    cause[ST_VOUT_UV]  = sample_valid & (sample_vout < vout_uv_lim);
    cause[ST_VOUT_OV]  = sample_valid & (sample_vout > vout_ov_lim);
    cause[ST_PIN_OP]   = sample_valid & (sample_pin > pin_op_lim);
    cause[ST_FET_BAD]  = fbad;
  end

  // a live cause wins over a clear, so persistent faults stay set
  wire        do_clear    = clear_cmd | off_on;
  wire [15:0] next_status = (do_clear ? 16'h0000 : status) | cause;
  wire [15:0] new_events  = next_status & ~status & alert_en;
  wire        any_fault   = |next_status[ST_OC_FAULT:ST_UV_FAULT];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status       <= 16'h0000;
      alert_signal <= 1'b0;
      on_d         <= 1'b1;
    end else begin
      status <= next_status;
      on_d   <= output_on;
      // new event wins over clear or arbitration win
      if (|new_events) begin
        alert_signal <= 1'b1;
      end else if (do_clear || ara.won) begin
        alert_signal <= 1'b0;
      end
    end
  end

  // pin and gate outputs, all registered
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      alert_out_pin_o  <= 1'b0;
      alert_out_pin_oe <= 1'b0;
      hot_swap_on      <= 1'b0;
      sda_o            <= 1'b0;
      sda_oe           <= 1'b0;
    end else begin
      alert_out_pin_o  <= 1'b0;
      // open-drain: pull low while alert is asserted, or while it is idle if invert is set
      alert_out_pin_oe <= invert ? ~alert_signal : alert_signal;
      // only faults and the on bit gate the switch, warnings never do
      hot_swap_on      <= output_on & ~any_fault;
      sda_o            <= 1'b0;
      sda_oe           <= ara.sda_oe;
    end
  end

  assign ara.scl          = sync2[5];
  assign ara.sda          = sync2[6];
  assign ara.alert_active = alert_signal;
  assign ara.dev_addr     = dev_addr;

  ara_responder u_ara (
    .hclk    (hclk),
    .hresetn (hresetn),
    .bus     (ara)
  );

  // readback and peaks hold raw codes, no scaling
  wire w_pk_vin  = wr_now & (wr_addr == PEAK_VIN_OFS) & (hwdata[11:0] == 12'h000);
  wire w_pk_vout = wr_now & (wr_addr == PEAK_VOUT_OFS) & (hwdata[11:0] == 12'h000);
  wire w_pk_iout = wr_now & (wr_addr == CUR_PEAK_OFS) & (hwdata[11:0] == 12'h000);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      read_vin          <= 12'h000;
      read_vout         <= 12'h000;
      read_iout         <= 12'h000;
      peak_vin          <= 12'h000;
      peak_vout         <= 12'h000;
      current_peak_hold <= 12'h000;
    end else begin
      if (sample_valid) begin
        read_vin  <= sample_vin;
        read_vout <= sample_vout;
        read_iout <= sample_iout;
      end
      if (w_pk_vin) begin
        peak_vin <= 12'h000;
      end else if (sample_valid && sample_vin > peak_vin) begin
        peak_vin <= sample_vin;
      end
      if (w_pk_vout) begin
        peak_vout <= 12'h000;
      end else if (sample_valid && sample_vout > peak_vout) begin
        peak_vout <= sample_vout;
      end
      if (w_pk_iout) begin
        current_peak_hold <= 12'h000;
      end else if (sample_valid && sample_iout > current_peak_hold) begin
        current_peak_hold <= sample_iout;
      end
    end
  end

  // register writes in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend     <= 1'b0;
      wr_addr     <= 8'h00;
      output_on   <= 1'b1;
      invert      <= 1'b0;
      dev_addr    <= DEV_ADDR_RST;
      alert_en    <= ALERT_EN_RST;
      vout_uv_lim <= UV_LIMIT_RST;
      vout_ov_lim <= OV_LIMIT_RST;
      vin_uv_lim  <= UV_LIMIT_RST;
      vin_ov_lim  <= OV_LIMIT_RST;
      iout_oc_lim <= OV_LIMIT_RST;
      iout_w2_lim <= UV_LIMIT_RST;
      warn2_under <= 1'b0;
      pin_op_lim  <= PIN_LIMIT_RST;
    end else begin
      wr_pend <= addr_phase & hwrite;
      wr_addr <= haddr[7:0];
      if (w_ctrl) begin
        output_on <= hwdata[CTRL_ON_BIT];
        invert    <= hwdata[CTRL_INVERT_BIT];
        dev_addr  <= hwdata[CTRL_ADDR_LSB +: 7];
      end
      if (wr_now) begin
        case (wr_addr)
          ALERT_EN_OFS:   alert_en    <= hwdata[15:0];
          VOUT_UV_OFS:    vout_uv_lim <= hwdata[11:0];
          VOUT_OV_OFS:    vout_ov_lim <= hwdata[11:0];
          VIN_UV_OFS:     vin_uv_lim  <= hwdata[11:0];
          VIN_OV_OFS:     vin_ov_lim  <= hwdata[11:0];
          IOUT_OC_OFS:    iout_oc_lim <= hwdata[11:0];
          IOUT_WARN2_OFS: begin
            iout_w2_lim <= hwdata[11:0];
            warn2_under <= hwdata[WARN2_UNDER_BIT];
          end
          PIN_OP_OFS:     pin_op_lim  <= hwdata[15:0];
          default: ;
        endcase
      end
    end
  end

  // read mux, selected in the address phase
  logic [31:0] rd_mux;
  always_comb begin
    case (rd_ofs)
      CTRL_OFS:       rd_mux = {17'h00000, dev_addr, 5'h00, invert, output_on, 1'b0};
      ALERT_EN_OFS:   rd_mux = {16'h0000, alert_en};
      STATUS_OFS:     rd_mux = {16'h0000, status};
      VOUT_UV_OFS:    rd_mux = {20'h00000, vout_uv_lim};
      VOUT_OV_OFS:    rd_mux = {20'h00000, vout_ov_lim};
      VIN_UV_OFS:     rd_mux = {20'h00000, vin_uv_lim};
      VIN_OV_OFS:     rd_mux = {20'h00000, vin_ov_lim};
      IOUT_OC_OFS:    rd_mux = {20'h00000, iout_oc_lim};
      IOUT_WARN2_OFS: rd_mux = {15'h0000, warn2_under, 4'h0, iout_w2_lim};
      PIN_OP_OFS:     rd_mux = {16'h0000, pin_op_lim};
      READ_VIN_OFS:   rd_mux = {20'h00000, read_vin};
      READ_VOUT_OFS:  rd_mux = {20'h00000, read_vout};
      READ_IOUT_OFS:  rd_mux = {20'h00000, read_iout};
      PEAK_VIN_OFS:   rd_mux = {20'h00000, peak_vin};
      PEAK_VOUT_OFS:  rd_mux = {20'h00000, peak_vout};
      CUR_PEAK_OFS:   rd_mux = {20'h00000, current_peak_hold};
      LINE_STATE_OFS: rd_mux = {29'h00000000, sync2[7], hot_swap_on, alert_signal};
      default:        rd_mux = 32'h00000000;
    endcase
  end

  // zero wait states, always okay; hsize is accepted as a word
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (addr_phase && !hwrite) begin
        hrdata <= rd_mux;
      end
    end
  end

endmodule

// [sim/fault_warning_alert_logic_checker.sv]
// Purpose: port-level checks of the alert block
// Assumes: pull-ups on alert and sda wires
// Notes:   bound to the block at the foot of this file
`timescale 1ns/1ps
module fault_warning_alert_logic_checker
  import alert_pkg::*;
(
  // clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // events
  input wire logic        uv_pin_event,
  input wire logic        ov_pin_event,
  input wire logic        oc_timer_expired,
  input wire logic        regulation_timer_active_flag,
  input wire logic        fet_health_bad,
  input wire logic        sample_valid,
  input wire logic        cml_error,
  // outputs and pins
  input wire logic        hot_swap_on,
  input wire logic        alert_out_pin_o,
  input wire logic        alert_out_pin_oe,
  input wire logic        scl_i,
  input wire logic        sda_o,
  input wire logic        sda_oe
);
  logic [4:0] pins_q;
  logic [3:0] evt_age;
  logic [3:0] cut_age;
  wire  [4:0] pins   = {uv_pin_event, ov_pin_event, oc_timer_expired,
                        regulation_timer_active_flag, fet_health_bad};
  wire        wr_aph = hsel && htrans[1] && hready && hwrite;
  wire        evt    = wr_aph || sample_valid || cml_error || pins != pins_q;
  // only fault pins or a control write may cut the output
  wire        cut    = (wr_aph && haddr[7:0] == CTRL_OFS) || |(pins[4:2] & ~pins_q[4:2]);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pins_q  <= 5'h00;
      evt_age <= 4'hF;
      cut_age <= 4'hF;
    end else begin
      pins_q  <= pins;
      evt_age <= evt ? 4'h0 : evt_age + {3'h0, evt_age != 4'hF};
      cut_age <= cut ? 4'h0 : cut_age + {3'h0, cut_age != 4'hF};
    end
  end
  default clocking dc @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  sequence s_fault_rise;
    $rose(uv_pin_event) || $rose(ov_pin_event) || $rose(oc_timer_expired);
  endsequence
  sequence s_gate_off;
    ##[2:5] !hot_swap_on;
  endsequence
  chk_reset_quiet: assert property ($rose(hresetn) |-> !alert_out_pin_oe && !sda_oe)
    else $error("pins driven just after reset");
  chk_sink_only: assert property (!alert_out_pin_o && !sda_o)
    else $error("open-drain pin driven high");
  chk_fault_cut: assert property (s_fault_rise |-> s_gate_off)
    else $error("fault left the output on");
  chk_warn_keeps_on: assert property ($fell(hot_swap_on) |-> cut_age <= 4'h4)
    else $error("output cut without fault or command");
  chk_alert_cause: assert property ($rose(alert_out_pin_oe) |-> evt_age <= 4'h4)
    else $error("alert raised without new event");
  chk_alert_release: assert property ($fell(alert_out_pin_oe) |-> evt_age <= 4'h4 || scl_i)
    else $error("alert released without clear or win");
  chk_sda_on_low: assert property ($changed(sda_oe) |-> !scl_i)
    else $error("sda moved while scl high");
  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus stalled or errored");
endmodule
bind fault_warning_alert_logic fault_warning_alert_logic_checker chk (
  .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hreadyout, .hresp,
  .uv_pin_event, .ov_pin_event, .oc_timer_expired, .regulation_timer_active_flag,
  .fet_health_bad, .sample_valid, .cml_error, .hot_swap_on, .alert_out_pin_o,
  .alert_out_pin_oe, .scl_i, .sda_o, .sda_oe);

// [sim/smbus_host_model.sv]
// Purpose: smbus host issuing alert response reads
// Assumes: pull-up on sda, scl idles high between frames
// Notes:   a lower-address rival can join the data byte
`timescale 1ns/1ps
module smbus_host_model
  import alert_pkg::*;
(
  // clock
  input  wire logic hclk,
  // device drive
  input  wire logic dev_sda_oe,
  // bus wires
  output logic      scl,
  output wire logic sda
);
  logic host_low;
  logic rival_low;
  assign sda = !(host_low || rival_low || dev_sda_oe);
  initial begin
    scl       = 1'b1;
    host_low  = 1'b0;
    rival_low = 1'b0;
  end
  task automatic half();
    repeat (8) @(posedge hclk);
  endtask
  // data moves two cycles after scl falls, never on the edge
  task automatic bit_io(input logic h, input logic r, output logic b);
    repeat (2) @(posedge hclk);
    host_low  <= h;
    rival_low <= r;
    half();
    scl <= 1'b1;
    half();
    b = sda;
    scl <= 1'b0;
  endtask
  task automatic ara_read(input logic rival_on, input logic [6:0] rival_addr,
                          output logic [7:0] got, output logic ack);
    logic [7:0] a;
    logic [7:0] r;
    logic       b;
    a = {ARA_ADDR, 1'b1};
    r = {rival_addr, 1'b1};
    host_low <= 1'b1;
    half();
    scl <= 1'b0;
    for (int i = 7; i >= 0; i--) begin
      bit_io(!a[i], 1'b0, b);
    end
    bit_io(1'b0, 1'b0, b);
    ack = !b;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b0, rival_on && !r[i], b);
      got[i] = b;
    end
    bit_io(1'b0, 1'b0, b);
    repeat (2) @(posedge hclk);
    host_low <= 1'b1;
    half();
    scl <= 1'b1;
    half();
    host_low <= 1'b0;
    half();
  endtask
endmodule

// [sim/fault_warning_alert_logic_tb_top.sv]
// Purpose: self-checking bench for the alert block
// Assumes: pull-ups on the alert and sda wires
// Notes:   register writes add one idle cycle before the next access
`timescale 1ns/1ps
module fault_warning_alert_logic_tb_top;
  import alert_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, sv, cml, rflag, fet;
  logic [1:0]  htrans;
  logic [2:0]  hsize, fp;
  logic [31:0] haddr, hwdata;
  logic [11:0] vout;
  wire  [31:0] hrdata;
  wire         hreadyout, hresp, hot_on, alert_o, alert_oe, scl, sda, sda_o, sda_oe;
  int          n_errors, compares;
  fault_warning_alert_logic dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .uv_pin_event(fp[0]), .ov_pin_event(fp[1]),
    .oc_timer_expired(fp[2]), .regulation_timer_active_flag(rflag), .fet_health_bad(fet),
    .sample_valid(sv), .sample_vin(12'h800), .sample_vout(vout), .sample_iout(12'h000),
    .sample_pin(16'h0000), .cml_error(cml), .hot_swap_on(hot_on), .alert_out_pin_i(!alert_oe),
    .alert_out_pin_o(alert_o), .alert_out_pin_oe(alert_oe), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe(sda_oe));
  smbus_host_model host (.hclk(hclk), .dev_sda_oe(sda_oe), .scl(scl), .sda(sda));
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  task automatic conclude();
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] e);
    compares++;
    if (got !== e) begin
      n_errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, e);
    end
  endtask
  task automatic pin(input logic got, input logic e);
    check({31'h0, got}, {31'h0, e});
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
  endtask
  task automatic wait_rdy();
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1 && n < 50) begin
      n++;
      @(posedge hclk);
    end
    if (n == 50) begin
      n_errors++;
      $display("MISMATCH at %0t: bus hang", $time);
      conclude();
    end
  endtask
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    ahb(1'b1, a, d, q);
    tick(1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    ahb(1'b0, a, 32'h0, q);
    check(q, e);
  endtask
  task automatic clr();
    wr(CTRL_OFS, 32'h0000_4003);
    tick(2);
  endtask
  task automatic smp(input logic [11:0] v);
    sv   <= 1'b1;
    vout <= v;
    tick(1);
    sv   <= 1'b0;
    tick(3);
  endtask
  task automatic pulse_cml();
    cml <= 1'b1;
    tick(1);
    cml <= 1'b0;
    tick(4);
  endtask
  task automatic t_reset();
    pin(alert_oe, 1'b0);
    rd(ALERT_EN_OFS, 32'h0000_8000);
    rd(STATUS_OFS, 32'h0);
    rd(VOUT_OV_OFS, 32'h0000_0FFF);
    rd(8'h80, 32'h0);
    fet <= 1'b1;
    tick(6);
    pin(alert_oe, 1'b1);
    fet <= 1'b0;
    tick(4);
    rd(STATUS_OFS, 32'h0000_8000);
    clr();
    pin(alert_oe, 1'b0);
    $display("done: reset");
  endtask
  task automatic t_vout();
    wr(ALERT_EN_OFS, 32'h0000_8200);
    wr(VOUT_UV_OFS, 32'h0000_0100);
    smp(12'h100);
    pin(alert_oe, 1'b0);
    smp(12'h0FF);
    pin(alert_oe, 1'b1);
    rd(READ_VOUT_OFS, 32'h0000_00FF);
    rd(PEAK_VOUT_OFS, 32'h0000_0100);
    rd(STATUS_OFS, 32'h0000_0200);
    clr();
    pin(alert_oe, 1'b0);
    rd(STATUS_OFS, 32'h0);
    smp(12'h0FE);
    pin(alert_oe, 1'b1);
    clr();
    wr(VOUT_UV_OFS, 32'h0);
    $display("done: vout warning");
  endtask
  task automatic t_faults();
    wr(ALERT_EN_OFS, 32'h0000_8007);
    for (int i = 0; i < 3; i++) begin
      fp <= 3'h1 << i;
      tick(6);
      pin(hot_on, 1'b0);
      pin(alert_oe, 1'b1);
      fp <= 3'h0;
      tick(4);
      rd(STATUS_OFS, 32'h1 << i);
      pin(hot_on, 1'b0);
      clr();
      tick(2);
      pin(hot_on, 1'b1);
    end
    fp[0] <= 1'b1;
    tick(6);
    clr();
    pin(alert_oe, 1'b0);
    rd(STATUS_OFS, 32'h1);
    fp[0] <= 1'b0;
    tick(4);
    clr();
    $display("done: faults");
  endtask
  task automatic t_warn();
    wr(ALERT_EN_OFS, 32'h0000_8018);
    pulse_cml();
    rflag <= 1'b1;
    tick(4);
    rflag <= 1'b0;
    tick(4);
    pin(alert_oe, 1'b1);
    pin(hot_on, 1'b1);
    rd(STATUS_OFS, 32'h0000_0018);
    wr(CTRL_OFS, 32'h0000_4000);
    wr(CTRL_OFS, 32'h0000_4002);
    tick(2);
    pin(alert_oe, 1'b0);
    rd(STATUS_OFS, 32'h0);
    wr(CTRL_OFS, 32'h0000_4006);
    tick(2);
    pin(alert_oe, 1'b1);
    wr(CTRL_OFS, 32'h0000_4002);
    tick(2);
    $display("done: warnings");
  endtask
  task automatic t_ara();
    logic [7:0] b;
    logic       ack;
    wr(ALERT_EN_OFS, 32'h0000_8008);
    pulse_cml();
    host.ara_read(1'b1, 7'h20, b, ack);
    pin(ack, 1'b1);
    check({24'h0, b}, 32'h0000_0041);
    pin(alert_oe, 1'b1);
    host.ara_read(1'b0, 7'h00, b, ack);
    check({24'h0, b[7:1], 1'b0}, {24'h0, DEV_ADDR_RST, 1'b0});
    pin(alert_oe, 1'b0);
    pulse_cml();
    pin(alert_oe, 1'b0);
    rd(STATUS_OFS, 32'h0000_0008);
    clr();
    rd(STATUS_OFS, 32'h0);
    $display("done: alert response");
  endtask
  initial begin
    hresetn  = 1'b0;
    hsel     = 1'b1;
    hsize    = 3'h2;
    htrans   = 2'h0;
    haddr    = 32'h0;
    hwrite   = 1'b0;
    hwdata   = 32'h0;
    fp       = 3'h0;
    rflag    = 1'b0;
    fet      = 1'b0;
    sv       = 1'b0;
    cml      = 1'b0;
    vout     = 12'h800;
    n_errors = 0;
    compares = 0;
    tick(6);
    hresetn <= 1'b1;
    tick(3);
    t_reset();
    t_vout();
    t_faults();
    t_warn();
    t_ara();
    conclude();
  end
endmodule
